/* File: sbpv_defines.svh */
// Constants of the sensor-break and process-value front end
`ifndef SBPV_DEFINES_SVH
`define SBPV_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SBPV_ADDR_CTRL     8'h00
`define SBPV_ADDR_OUT_HI   8'h04
`define SBPV_ADDR_OUT_LO   8'h08
`define SBPV_ADDR_FALLBACK 8'h0c
`define SBPV_ADDR_SHIFT    8'h10
`define SBPV_ADDR_LIN_TOP  8'h14
`define SBPV_ADDR_LIN_BOT  8'h18
`define SBPV_ADDR_SCL_TOP  8'h1c
`define SBPV_ADDR_SCL_BOT  8'h20
`define SBPV_ADDR_COMMS_PV 8'h24
`define SBPV_ADDR_STATUS   8'h28
`define SBPV_ADDR_PV       8'h2c
`define SBPV_ADDR_DEMAND   8'h30

// ----------------------------------------------------------------
// CTRL field positions
// ----------------------------------------------------------------
`define SBPV_CTRL_MODE_LSB  0
`define SBPV_CTRL_KIND_LSB  2
`define SBPV_CTRL_OTYP_LSB  4
`define SBPV_CTRL_LEVEL_LSB 6

// ----------------------------------------------------------------
// Value limits (percent in tenths, millivolts in hundredths)
// ----------------------------------------------------------------
`define SBPV_PCT_FULL   16'sh03e8
`define SBPV_PCT_ZERO   16'sh0000
`define SBPV_MV_MIN     (-16'sh03e8)
`define SBPV_MV_MAX     16'sh1f40
`define SBPV_BRK_DIV    32'sh0000_0014

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SBPV_RST_OUT_HI   16'sh03e8
`define SBPV_RST_OUT_LO   (-16'sh03e8)
`define SBPV_RST_LIN_TOP  16'sh1f40
`define SBPV_RST_LIN_BOT  (-16'sh03e8)
`define SBPV_RST_SCL_TOP  16'sh1f40
`define SBPV_RST_SCL_BOT  (-16'sh03e8)

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SBPV_CLK_KHZ        25000
`define SBPV_STALE_MS       5000
`define SBPV_STALE_CYCLES   (`SBPV_STALE_MS * `SBPV_CLK_KHZ)
`define SBPV_FLASH_MS       250
`define SBPV_FLASH_CYCLES   (`SBPV_FLASH_MS * `SBPV_CLK_KHZ)

`endif

/* File: sbpv_pkg.sv */
// Types of the sensor-break and process-value front end
`default_nettype none
package sbpv_pkg;

  typedef enum logic [1:0] {mode_off, mode_on, mode_latch, mode_rsvd} sbpv_mode_t;
  typedef enum logic [1:0] {kind_tc, kind_rtd, kind_linear, kind_comms} sbpv_kind_t;
  typedef enum logic [1:0] {otyp_heat_cool, otyp_heat, otyp_cool, otyp_rsvd} sbpv_otyp_t;
  typedef enum logic [1:0] {lvl_1, lvl_2, lvl_3, lvl_conf} sbpv_level_t;

  typedef struct packed {
    sbpv_mode_t         mode;
    sbpv_kind_t         kind;
    sbpv_otyp_t         otyp;
    sbpv_level_t        level;
    logic signed [15:0] hi;
    logic signed [15:0] lo;
    logic signed [15:0] fb;
    logic signed [15:0] shift;
    logic signed [15:0] lin_top;
    logic signed [15:0] lin_bot;
    logic signed [15:0] scl_top;
    logic signed [15:0] scl_bot;
    logic signed [15:0] raw_pv;
    logic signed [15:0] pv;
    logic signed [15:0] demand;
    logic [31:0]        stale_cnt;
    logic               stale;
    logic               lin_brk;
    logic [31:0]        flash_cnt;
    logic               flash;
    logic [2:0]         open_sync;
    logic               open_flt;
    logic [2:0]         ack_sync;
    logic               ack_flt;
    logic               ack_prev;
    logic               brk;
    logic               alarm;
    logic               lamp;
    logic               relay;
    logic [31:0]        rdata;
  } sbpv_state_t;

endpackage : sbpv_pkg

`default_nettype wire

/* File: sbpv_front.sv */
// Sensor-break supervision, linear scaling and offset of the process value
`timescale 1ns/1ps
`default_nettype none
`include "sbpv_defines.svh"

module sbpv_front
  import sbpv_pkg::*;
#(
  parameter int unsigned STALE_CYCLES = `SBPV_STALE_CYCLES,
  parameter int unsigned FLASH_CYCLES = `SBPV_FLASH_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               ce,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output var  logic [31:0]        rdata,
  input  wire logic signed [15:0] sample_mv,
  input  wire logic signed [15:0] sample_lin_pv,
  input  wire logic               sample_valid,
  input  wire logic signed [15:0] control_demand,
  input  wire logic               sensor_open_pin,
  input  wire logic               ack_key_pin,
  output var  logic signed [15:0] pv_out,
  output var  logic signed [15:0] demand_out,
  output var  logic               alarm_lamp,
  output var  logic               alarm_relay,
  output var  logic               break_flag
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
                                               input logic signed [15:0] lo,
                                               input logic signed [15:0] hi);
    clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction : clamp

  function automatic logic signed [15:0] type_top(input sbpv_otyp_t t);
    type_top = (t == otyp_cool) ? `SBPV_PCT_ZERO : `SBPV_PCT_FULL;
  endfunction : type_top

  function automatic logic signed [15:0] type_bot(input sbpv_otyp_t t);
    type_bot = (t == otyp_heat) ? `SBPV_PCT_ZERO : -`SBPV_PCT_FULL;
  endfunction : type_bot

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sh0000_7fff) begin
      sat16 = 16'sh7fff;
    end else if (v < -32'sh0000_8000) begin
      sat16 = -16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  // Straight-line map; a zero span leaves the bottom of range rather than divide by zero
  function automatic logic signed [15:0] scale(input logic signed [15:0] mv,
                                               input logic signed [15:0] mt,
                                               input logic signed [15:0] mb,
                                               input logic signed [15:0] st,
                                               input logic signed [15:0] sb);
    logic signed [31:0] den;
    logic signed [31:0] num;
    den = 32'(mt) - 32'(mb);
    num = (32'(mv) - 32'(mb)) * (32'(st) - 32'(sb));
    if (den == 32'sh0) begin
      scale = sb;
    end else begin
      scale = sat16(32'(sb) + num / den);
    end
  endfunction : scale

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam sbpv_state_t ST_RST = '{
    mode: mode_on, kind: kind_linear, otyp: otyp_heat_cool, level: lvl_1,
    hi: `SBPV_RST_OUT_HI, lo: `SBPV_RST_OUT_LO, fb: 16'sh0000, shift: 16'sh0000,
    lin_top: `SBPV_RST_LIN_TOP, lin_bot: `SBPV_RST_LIN_BOT,
    scl_top: `SBPV_RST_SCL_TOP, scl_bot: `SBPV_RST_SCL_BOT,
    raw_pv: 16'sh0000, pv: 16'sh0000, demand: 16'sh0000,
    stale_cnt: 32'h0000_0000, stale: 1'b0, lin_brk: 1'b0,
    flash_cnt: 32'h0000_0000, flash: 1'b0,
    open_sync: 3'h0, open_flt: 1'b0, ack_sync: 3'h0, ack_flt: 1'b0, ack_prev: 1'b0,
    brk: 1'b0, alarm: 1'b0, lamp: 1'b0, relay: 1'b0, rdata: 32'h0000_0000
  };

  sbpv_state_t        s_ff;
  sbpv_state_t        nxt_s;
  logic signed [31:0] margin;
  logic               ack_pulse;
  logic               wr_conf;
  logic               wr_l3;

  always_comb begin
    nxt_s     = s_ff;
    margin    = (32'(s_ff.lin_top) - 32'(s_ff.lin_bot)) / `SBPV_BRK_DIV;
    ack_pulse = s_ff.ack_flt & ~s_ff.ack_prev;
    wr_conf   = wr && (s_ff.level == lvl_conf);
    wr_l3     = wr && (s_ff.level == lvl_3 || s_ff.level == lvl_conf);

    // ----------------------------------------------------------------
    // Pin synchronisers: a change counts once stages two and three agree
    // ----------------------------------------------------------------
    nxt_s.open_sync = {s_ff.open_sync[1:0], sensor_open_pin};
    nxt_s.ack_sync  = {s_ff.ack_sync[1:0], ack_key_pin};
    if (s_ff.open_sync[1] == s_ff.open_sync[2]) begin
      nxt_s.open_flt = s_ff.open_sync[2];
    end
    if (s_ff.ack_sync[1] == s_ff.ack_sync[2]) begin
      nxt_s.ack_flt = s_ff.ack_sync[2];
    end
    nxt_s.ack_prev = s_ff.ack_flt;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (wr) begin
      unique case (addr)
        `SBPV_ADDR_CTRL: begin
          nxt_s.level = sbpv_level_t'(wdata[`SBPV_CTRL_LEVEL_LSB +: 2]);
          if (wr_conf) begin
            nxt_s.mode = sbpv_mode_t'(wdata[`SBPV_CTRL_MODE_LSB +: 2]);
            nxt_s.kind = sbpv_kind_t'(wdata[`SBPV_CTRL_KIND_LSB +: 2]);
            nxt_s.otyp = sbpv_otyp_t'(wdata[`SBPV_CTRL_OTYP_LSB +: 2]);
          end
        end
        `SBPV_ADDR_OUT_HI:   nxt_s.hi = wdata[15:0];
        `SBPV_ADDR_OUT_LO:   nxt_s.lo = wdata[15:0];
        `SBPV_ADDR_FALLBACK: nxt_s.fb = wdata[15:0];
        `SBPV_ADDR_SHIFT: begin
          if (wr_l3) begin
            nxt_s.shift = wdata[15:0];
          end
        end
        `SBPV_ADDR_LIN_TOP: begin
          if (wr_conf) begin
            nxt_s.lin_top = clamp(wdata[15:0], `SBPV_MV_MIN, `SBPV_MV_MAX);
          end
        end
        `SBPV_ADDR_LIN_BOT: begin
          if (wr_conf) begin
            nxt_s.lin_bot = clamp(wdata[15:0], `SBPV_MV_MIN, `SBPV_MV_MAX);
          end
        end
        `SBPV_ADDR_SCL_TOP: begin
          if (wr_conf) begin
            nxt_s.scl_top = wdata[15:0];
          end
        end
        `SBPV_ADDR_SCL_BOT: begin
          if (wr_conf) begin
            nxt_s.scl_bot = wdata[15:0];
          end
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // Output limits and fallback level
    // ----------------------------------------------------------------
    // Re-clipped every cycle so a change of output type also pulls the limits in
    nxt_s.hi = clamp(nxt_s.hi, type_bot(nxt_s.otyp), type_top(nxt_s.otyp));
    nxt_s.lo = clamp(nxt_s.lo, type_bot(nxt_s.otyp), type_top(nxt_s.otyp));
    if (nxt_s.fb > nxt_s.hi) begin
      nxt_s.fb = nxt_s.hi;
    end else if (nxt_s.fb < nxt_s.lo) begin
      nxt_s.fb = nxt_s.lo;
    end

    // ----------------------------------------------------------------
    // Measurement path
    // ----------------------------------------------------------------
    if (s_ff.kind == kind_comms) begin
      if (wr && addr == `SBPV_ADDR_COMMS_PV) begin
        nxt_s.raw_pv    = wdata[15:0];
        nxt_s.stale_cnt = 32'h0000_0000;
        nxt_s.stale     = 1'b0;
      end else if (s_ff.stale_cnt >= STALE_CYCLES - 1) begin
        nxt_s.stale = 1'b1;
      end else begin
        nxt_s.stale_cnt = s_ff.stale_cnt + 32'h0000_0001;
      end
      nxt_s.lin_brk = 1'b0;
    end else begin
      nxt_s.stale_cnt = 32'h0000_0000;
      nxt_s.stale     = 1'b0;
      if (sample_valid) begin
        if (s_ff.kind == kind_linear) begin
          nxt_s.raw_pv = scale(sample_mv, s_ff.lin_top, s_ff.lin_bot,
                               s_ff.scl_top, s_ff.scl_bot);
          nxt_s.lin_brk = (32'(sample_mv) > 32'(s_ff.lin_top) + margin) ||
                          (32'(sample_mv) < 32'(s_ff.lin_bot) - margin);
        end else begin
          nxt_s.raw_pv  = sample_lin_pv;
          nxt_s.lin_brk = 1'b0;
        end
      end
    end
    nxt_s.pv = sat16(32'(s_ff.raw_pv) + 32'(s_ff.shift));

    // Open circuit is watched in every kind except a comms-fed value
    nxt_s.brk = s_ff.stale | s_ff.lin_brk |
                (s_ff.open_flt & (s_ff.kind != kind_comms));

    // ----------------------------------------------------------------
    // Output demand
    // ----------------------------------------------------------------
    if (!s_ff.brk) begin
      nxt_s.demand = control_demand;
    end else if (s_ff.mode == mode_on || s_ff.mode == mode_latch) begin
      nxt_s.demand = (s_ff.fb <= s_ff.hi && s_ff.fb >= s_ff.lo) ? s_ff.fb : s_ff.hi;
    end else begin
      nxt_s.demand = type_top(s_ff.otyp);
    end

    // ----------------------------------------------------------------
    // Alarm
    // ----------------------------------------------------------------
    unique case (s_ff.mode)
      mode_on:    nxt_s.alarm = s_ff.brk;
      mode_latch: begin
        if (s_ff.brk) begin
          nxt_s.alarm = 1'b1;
        end else if (ack_pulse) begin
          nxt_s.alarm = 1'b0;
        end
      end
      mode_off, mode_rsvd: nxt_s.alarm = 1'b0;
    endcase

    // Flash phase keeps running, so a fresh alarm can start with the lamp lit or dark
    if (s_ff.flash_cnt >= FLASH_CYCLES - 1) begin
      nxt_s.flash_cnt = 32'h0000_0000;
      nxt_s.flash     = ~s_ff.flash;
    end else begin
      nxt_s.flash_cnt = s_ff.flash_cnt + 32'h0000_0001;
    end
    nxt_s.lamp  = s_ff.alarm & ~s_ff.flash;
    nxt_s.relay = s_ff.alarm;

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    nxt_s.rdata = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        `SBPV_ADDR_CTRL:     nxt_s.rdata = {24'h00_0000, s_ff.level, s_ff.otyp,
                                            s_ff.kind, s_ff.mode};
        `SBPV_ADDR_OUT_HI:   nxt_s.rdata = {16'h0000, s_ff.hi};
        `SBPV_ADDR_OUT_LO:   nxt_s.rdata = {16'h0000, s_ff.lo};
        `SBPV_ADDR_FALLBACK: nxt_s.rdata = {16'h0000, s_ff.fb};
        `SBPV_ADDR_SHIFT:    nxt_s.rdata = {16'h0000, s_ff.shift};
        `SBPV_ADDR_LIN_TOP:  nxt_s.rdata = {16'h0000, s_ff.lin_top};
        `SBPV_ADDR_LIN_BOT:  nxt_s.rdata = {16'h0000, s_ff.lin_bot};
        `SBPV_ADDR_SCL_TOP:  nxt_s.rdata = {16'h0000, s_ff.scl_top};
        `SBPV_ADDR_SCL_BOT:  nxt_s.rdata = {16'h0000, s_ff.scl_bot};
        `SBPV_ADDR_COMMS_PV: nxt_s.rdata = {16'h0000, s_ff.raw_pv};
        `SBPV_ADDR_STATUS:   nxt_s.rdata = {26'h000_0000, s_ff.relay, s_ff.open_flt,
                                            s_ff.lin_brk, s_ff.stale, s_ff.alarm, s_ff.brk};
        `SBPV_ADDR_PV:       nxt_s.rdata = {16'h0000, s_ff.pv};
        `SBPV_ADDR_DEMAND:   nxt_s.rdata = {16'h0000, s_ff.demand};
        default:             nxt_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_ff <= ST_RST;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign rdata       = s_ff.rdata;
  assign pv_out      = s_ff.pv;
  assign demand_out  = s_ff.demand;
  assign alarm_lamp  = s_ff.lamp;
  assign alarm_relay = s_ff.relay;
  assign break_flag  = s_ff.brk;

endmodule : sbpv_front

`default_nettype wire

/* File: sbpv_checker.sv */
// Port assertions for the sensor-break and process-value front end
`timescale 1ns/1ps
`default_nettype none
module sbpv_checker #(
  parameter int unsigned FLASH_CYCLES = 4
) (
  input wire logic               sys_clk,
  input wire logic               resetn,
  input wire logic               ce,
  input wire logic               rd,
  input wire logic [31:0]        rdata,
  input wire logic signed [15:0] pv_out,
  input wire logic signed [15:0] demand_out,
  input wire logic               alarm_lamp,
  input wire logic               alarm_relay,
  input wire logic               break_flag
);
  // ----------------------------------------------------------------
  // Lit-run counter: a lamp stuck on would pass a plain level check
  // ----------------------------------------------------------------
  logic [31:0] lit_ff;
  always_ff @(posedge sys_clk) begin
    if (!resetn || !alarm_lamp) begin
      lit_ff <= 32'h0;
    end else if (ce) begin
      lit_ff <= lit_ff + 32'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_rd_idle; ce && !rd |=> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_upper; ce && rd |=> rdata[31:16] == 16'h0; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper half set");
  property p_lamp_relay; alarm_lamp |-> alarm_relay; endproperty
  a_lamp_relay: assert property (p_lamp_relay) else $error("lamp lit without relay");
  property p_relay_rise; $rose(alarm_relay) |-> $past(break_flag) || $past(break_flag, 2);
  endproperty
  a_relay_rise: assert property (p_relay_rise) else $error("relay without break");
  property p_relay_fall; $fell(alarm_relay) |-> !break_flag && !$past(break_flag); endproperty
  a_relay_fall: assert property (p_relay_fall) else $error("relay cleared in break");
  property p_lamp_len; alarm_lamp |-> lit_ff < FLASH_CYCLES; endproperty
  a_lamp_len: assert property (p_lamp_len) else $error("lamp does not flash");
  property p_dem_rng; demand_out >= -16'sh03e8 && demand_out <= 16'sh03e8; endproperty
  a_dem_rng: assert property (p_dem_rng) else $error("demand out of range");
  property p_freeze; !ce |=> $stable(pv_out) && $stable(demand_out) && $stable(alarm_relay);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved with clock enable low");
  c_relay: cover property ($rose(alarm_relay));
  c_lamp: cover property ($rose(alarm_lamp));
  c_clear: cover property ($fell(break_flag));
endmodule : sbpv_checker
bind sbpv_front sbpv_checker #(.FLASH_CYCLES(FLASH_CYCLES)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .rd(rd), .rdata(rdata), .pv_out(pv_out),
  .demand_out(demand_out), .alarm_lamp(alarm_lamp), .alarm_relay(alarm_relay),
  .break_flag(break_flag));
`default_nettype wire

/* File: sbpv_sensor.sv */
// Behavioural sensor that feeds periodic samples to the front end
`timescale 1ns/1ps
`default_nettype none
module sbpv_sensor (
  input  wire logic               sys_clk,
  output logic signed [15:0]      sample_mv,
  output logic signed [15:0]      sample_lin_pv,
  output logic                    sample_valid,
  output logic                    sensor_open_pin
);
  logic signed [15:0] level_mv;
  logic               open_req;
  int                 gap;
  int                 cnt;
  initial begin
    level_mv = 16'sh0000;
    open_req = 1'b0;
    gap = 3;
    cnt = 0;
    sample_mv = 16'sh0000;
    sample_lin_pv = 16'sh0000;
    sample_valid = 1'b0;
    sensor_open_pin = 1'b0;
  end
  // Between samples the data lines toggle so stale values cannot pass as fresh
  always @(posedge sys_clk) begin
    sensor_open_pin <= open_req;
    if (cnt >= gap) begin
      cnt <= 0;
      sample_valid <= 1'b1;
      sample_mv <= level_mv;
      sample_lin_pv <= level_mv;
    end else begin
      cnt <= cnt + 1;
      sample_valid <= 1'b0;
      sample_mv <= ~sample_mv;
      sample_lin_pv <= ~sample_lin_pv;
    end
  end
endmodule : sbpv_sensor
`default_nettype wire

/* File: test_sensor_break_and_pv_scaling.sv */
// Self-checking testbench of the sensor-break and process-value front end
`timescale 1ns/1ps
`default_nettype none
`include "sbpv_defines.svh"
module test_sensor_break_and_pv_scaling;
  logic               sys_clk, resetn, ce, wr, rd, ack_key_pin, sample_valid, sensor_open_pin;
  logic               alarm_lamp, alarm_relay, break_flag;
  logic [7:0]         addr;
  logic [31:0]        wdata, rdata, lfsr;
  logic signed [15:0] sample_mv, sample_lin_pv, control_demand, pv_out, demand_out, mv;
  int                 fails, tests_run, i, n;
  logic [31:0] rst_tab [9] = '{32'h09, 32'h03e8, 32'hfc18, 32'h0, 32'h0, 32'h1f40, 32'hfc18,
                               32'h1f40, 32'hfc18};
  logic [15:0] band_mv [5] = '{16'h0820, 16'h0821, 16'h0140, 16'h013f, 16'h03e8};
  logic [7:0]  off_ctl [3] = '{8'hc8, 8'hdb, 8'he8};
  logic [15:0] off_dem [3] = '{16'h03e8, 16'h03e8, 16'h0000};
  sbpv_front #(.STALE_CYCLES(50), .FLASH_CYCLES(4)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sample_mv(sample_mv), .sample_lin_pv(sample_lin_pv),
    .sample_valid(sample_valid), .control_demand(control_demand),
    .sensor_open_pin(sensor_open_pin), .ack_key_pin(ack_key_pin), .pv_out(pv_out),
    .demand_out(demand_out), .alarm_lamp(alarm_lamp), .alarm_relay(alarm_relay),
    .break_flag(break_flag));
  sbpv_sensor sens (.sys_clk(sys_clk), .sample_mv(sample_mv), .sample_lin_pv(sample_lin_pv),
    .sample_valid(sample_valid), .sensor_open_pin(sensor_open_pin));
  always #20 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // Scaling 400..2000 onto 200..5000 is an exact factor of three, plus shift 7
  function automatic logic [15:0] exp_pv(input logic signed [15:0] v);
    return 16'(200 + 3 * (int'(v) - 400) + 7);
  endfunction : exp_pv
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    chk(rdata, e);
  endtask : rd_chk
  // Both end mid-cycle so the outputs compared next have settled
  task automatic lvl(input logic signed [15:0] v);
    @(posedge sys_clk);
    sens.level_mv <= v;
    repeat (15) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : lvl
  task automatic ack_pulse;
    @(posedge sys_clk);
    ack_key_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    ack_key_pin <= 1'b0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : ack_pulse
  task automatic chk_st(input logic b, input logic r);
    chk({30'h0, break_flag, alarm_relay}, {30'h0, b, r});
  endtask : chk_st
  task automatic end_sim;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_sim();
  end
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    {addr, wdata, wr, rd, ack_key_pin} = '0;
    control_demand = 16'sh0000;
    lfsr = 32'h9a6d;
    fails = 0;
    tests_run = 0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    for (i = 0; i < 9; i++) rd_chk(8'(i * 4), rst_tab[i]);
    rd_chk(8'hfc, 32'h0);
    wr_reg(`SBPV_ADDR_SHIFT, 32'h5);
    rd_chk(`SBPV_ADDR_SHIFT, 32'h0);
    wr_reg(`SBPV_ADDR_CTRL, 32'h89);
    wr_reg(`SBPV_ADDR_LIN_TOP, 32'h64);
    rd_chk(`SBPV_ADDR_LIN_TOP, 32'h1f40);
    wr_reg(`SBPV_ADDR_SHIFT, 32'h7);
    rd_chk(`SBPV_ADDR_SHIFT, 32'h7);
    wr_reg(`SBPV_ADDR_CTRL, 32'hc9);
    wr_reg(`SBPV_ADDR_LIN_TOP, 32'h07d0);
    wr_reg(`SBPV_ADDR_LIN_BOT, 32'h0190);
    wr_reg(`SBPV_ADDR_SCL_TOP, 32'h1388);
    wr_reg(`SBPV_ADDR_SCL_BOT, 32'h00c8);
    // Ends of the span first, then random readings inside it
    for (i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      mv = (i == 0) ? 16'sh0190 : (i == 1) ? 16'sh07d0 : 16'(400 + int'(lfsr[15:0]) % 1601);
      @(posedge sys_clk);
      control_demand <= 16'(int'(lfsr[27:16]) % 2001 - 1000);
      lvl(mv);
      chk({16'h0, pv_out}, {16'h0, exp_pv(mv)});
      chk_st(1'b0, 1'b0);
      chk({16'h0, demand_out}, {16'h0, control_demand});
    end
    @(posedge sys_clk);
    ce <= 1'b0;
    repeat (3) @(posedge sys_clk);
    ce <= 1'b1;
    for (i = 0; i < 5; i++) begin
      lvl(band_mv[i]);
      chk_st(i[0], i[0]);
    end
    for (i = 0; i < 3; i++) begin
      wr_reg(`SBPV_ADDR_CTRL, {24'h0, off_ctl[i]});
      lvl(16'sh013f);
      chk({16'h0, demand_out}, {16'h0, off_dem[i]});
      chk_st(1'b1, 1'b0);
      lvl(16'sh03e8);
    end
    wr_reg(`SBPV_ADDR_CTRL, 32'hc9);
    wr_reg(`SBPV_ADDR_OUT_HI, 32'h03e8);
    wr_reg(`SBPV_ADDR_FALLBACK, 32'h32);
    wr_reg(`SBPV_ADDR_OUT_HI, 32'h28);
    rd_chk(`SBPV_ADDR_FALLBACK, 32'h28);
    wr_reg(`SBPV_ADDR_FALLBACK, 32'h0);
    wr_reg(`SBPV_ADDR_OUT_LO, 32'ha);
    rd_chk(`SBPV_ADDR_FALLBACK, 32'ha);
    lvl(16'sh013f);
    chk({16'h0, demand_out}, 32'ha);
    lvl(16'sh03e8);
    wr_reg(`SBPV_ADDR_CTRL, 32'hd9);
    wr_reg(`SBPV_ADDR_OUT_LO, 32'hfe0c);
    rd_chk(`SBPV_ADDR_OUT_LO, 32'h0);
    wr_reg(`SBPV_ADDR_CTRL, 32'hca);
    sens.open_req <= 1'b1;
    lvl(16'sh03e8);
    ack_pulse();
    chk_st(1'b1, 1'b1);
    chk({16'h0, demand_out}, 32'ha);
    n = 0;
    repeat (16) @(negedge sys_clk) n += int'(alarm_lamp);
    chk({31'h0, n > 0 && n < 16}, 32'h1);
    sens.open_req <= 1'b0;
    lvl(16'sh03e8);
    chk_st(1'b0, 1'b1);
    ack_pulse();
    chk_st(1'b0, 1'b0);
    wr_reg(`SBPV_ADDR_CTRL, 32'hc1);
    lvl(16'sh04d2);
    chk({16'h0, pv_out}, 32'h04d9);
    wr_reg(`SBPV_ADDR_CTRL, 32'hc5);
    lvl(16'sh0100);
    chk({16'h0, pv_out}, 32'h0107);
    wr_reg(`SBPV_ADDR_CTRL, 32'hfd);
    wr_reg(`SBPV_ADDR_COMMS_PV, 32'h7b);
    for (n = 0; n < 300 && break_flag !== 1'b1; n++) @(negedge sys_clk);
    chk({31'h0, n >= 48 && n <= 56}, 32'h1);
    wr_reg(`SBPV_ADDR_COMMS_PV, 32'hc8);
    repeat (8) @(negedge sys_clk);
    chk({16'h0, pv_out}, 32'hcf);
    chk({31'h0, break_flag}, 32'h0);
    wr_reg(`SBPV_ADDR_LIN_TOP, 32'h2710);
    rd_chk(`SBPV_ADDR_LIN_TOP, 32'h1f40);
    wr_reg(`SBPV_ADDR_LIN_BOT, 32'hf830);
    rd_chk(`SBPV_ADDR_LIN_BOT, 32'hfc18);
    end_sim();
  end
endmodule : test_sensor_break_and_pv_scaling
`default_nettype wire
